// file: shared/rlpe_defs.svh
// Purpose: timing counts for reset, power and emulation control
// Assumes: counts are in oscillator periods, except RLPE_PHASE_PER_MCYC in phases
// Notes: guarded header
`ifndef RLPE_DEFS_SVH
`define RLPE_DEFS_SVH
`define RLPE_RST_OSC_PERIODS 5'd24
`define RLPE_OSC_PER_MCYC 12
`define RLPE_PHASE_PER_MCYC 3'd6
`define RLPE_PIN_RST 0
`define RLPE_PIN_OSC 1
`define RLPE_PIN_IRQ0 2
`define RLPE_PIN_IRQ1 3
`define RLPE_PIN_ALE 4
`define RLPE_PIN_PROG_STORE_STROBE_N 5
`define RLPE_PIN_RESET 6'h3D
`endif

// file: shared/rlpe_pkg.sv
// Purpose: types for reset, power and emulation control
// Assumes: nothing
// Notes: constants live in rlpe_defs.svh
package rlpe_pkg;
  typedef enum logic [2:0] {
    ST_RESET,
    ST_RUN,
    ST_IDLE,
    ST_PD,
    ST_PD_WAKE,
    ST_EMUL
  } mode_t;

  typedef struct packed {
    logic osc_run;
    logic phase;
    logic mcyc;
    logic core;
    logic periph;
  } clk_en_t;

  typedef struct packed {
    logic ale;
    logic ale_oe;
    logic prog_store_strobe_n_n;
    logic prog_store_strobe_n_oe;
    logic p0_float;
    logic p2_addr;
    logic port_hold;
    logic weak_pull;
  } pin_ctl_t;
endpackage

// file: design/reset_lowpower_emul_ctrl.sv
// Purpose: reset qualification, idle, power-down and emulation control
// Assumes: MCLK_I runs always; oscillator pin is sampled on it
// Notes: osc_in edges become enable pulses; core work stays in the core
`timescale 1ns/10ps
`include "rlpe_defs.svh"

// Functional notes
// - Reset pin forces ports asynchronously
// - Oscillator divided by two before timing
// - Idle stops core, peripherals run
// - Idle keeps core, RAM and registers
// - Enabled interrupt ends idle into service
// - Reset in idle restarts like power-on
// - Power-down stops the oscillator
// - Reset exit reinitialises registers, keeps RAM
// - Interrupt exit keeps registers and RAM
// - Low wake restarts oscillator, high completes
// - After return, resume past power-down instruction
// - Emulation floats port 0, pulls others
// - Emulation ends only by normal reset
// - Idle drives both strobes high
// - Power-down drives both strobes low
module reset_lowpower_emul_ctrl (
  // Clock and reset
  input  wire logic              MCLK_I,
  input  wire logic              SYS_RST_I,
  // Pins from outside
  input  wire logic              RST_PIN_I,
  input  wire logic              OSC_IN_I,
  input  wire logic              IRQ0_N_I,
  input  wire logic              IRQ1_N_I,
  input  wire logic              ALE_PIN_I,
  input  wire logic              PROG_STORE_STROBE_N_N_PIN_I,
  // From core
  input  wire logic              IDLE_REQ_I,
  input  wire logic              PD_REQ_I,
  input  wire logic              IRQ_PEND_I,
  input  wire logic              IRQ0_WAKE_EN_I,
  input  wire logic              IRQ1_WAKE_EN_I,
  input  wire logic              EXT_PROG_I,
  input  wire logic              ALE_CORE_I,
  input  wire logic              PROG_STORE_STROBE_N_N_CORE_I,
  // Status and enables
  output rlpe_pkg::mode_t        MODE_O,
  output rlpe_pkg::clk_en_t      CLK_EN_O,
  output logic                   CORE_RST_O,
  output logic                   WAKE_IRQ_O,
  output logic                   PORT_RST_O,
  // Pin control
  output rlpe_pkg::pin_ctl_t     PIN_CTL_O
);
  import rlpe_pkg::*;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] f;
    logic       osc_prev;
    logic       div;
    logic [2:0] ph_cnt;
    logic [4:0] rst_cnt;
    logic       emul_arm;
    mode_t      mode;
    clk_en_t    ce;
    logic       core_rst;
    logic       wake;
    pin_ctl_t   pc;
  } state_t;

  state_t r;
  state_t n;
  logic   port_rst;
  logic   osc_tick;
  logic   rst_hit;
  logic   wake_low;
  logic   wake_high;
  logic   phase;

  always_comb begin
    n = r;
    n.s1 = {PROG_STORE_STROBE_N_N_PIN_I, ALE_PIN_I, IRQ1_N_I, IRQ0_N_I, OSC_IN_I, RST_PIN_I};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = (r.f & (r.s2 ^ r.s3)) | (r.s2 & ~(r.s2 ^ r.s3));
    n.osc_prev = r.f[`RLPE_PIN_OSC];
    // Oscillator edges count only while it runs
    osc_tick = r.f[`RLPE_PIN_OSC] & ~r.osc_prev & r.ce.osc_run;
    phase = osc_tick & r.div;
    if (osc_tick) begin
      n.div = ~r.div;
    end
    if (phase) begin
      n.ph_cnt = (r.ph_cnt == `RLPE_PHASE_PER_MCYC - 3'd1) ? 3'h0 : r.ph_cnt + 3'h1;
    end
    // Reset qualification in oscillator periods
    rst_hit = 1'b0;
    if (!r.f[`RLPE_PIN_RST]) begin
      n.rst_cnt = 5'h00;
    end else if (r.rst_cnt == `RLPE_RST_OSC_PERIODS) begin
      rst_hit = 1'b1;
    end else if (osc_tick) begin
      n.rst_cnt = r.rst_cnt + 5'h01;
    end
    // Wake pins, sampled without any core enable
    wake_low = (IRQ0_WAKE_EN_I & ~r.f[`RLPE_PIN_IRQ0]) |
               (IRQ1_WAKE_EN_I & ~r.f[`RLPE_PIN_IRQ1]);
    wake_high = ~wake_low;
    // Emulation entry sampled while the reset pin is high
    if (r.f[`RLPE_PIN_RST]) begin
      n.emul_arm = ~r.f[`RLPE_PIN_ALE] & r.f[`RLPE_PIN_PROG_STORE_STROBE_N];
    end
    n.wake = 1'b0;
    if (rst_hit) begin
      n.mode = ST_RESET;
    end else begin
      unique case (r.mode)
        ST_RESET: begin
          if (!r.f[`RLPE_PIN_RST]) begin
            n.mode = (r.emul_arm && !r.f[`RLPE_PIN_ALE]) ? ST_EMUL : ST_RUN;
          end
        end
        ST_RUN: begin
          if (PD_REQ_I) begin
            n.mode = ST_PD;
          end else if (IDLE_REQ_I) begin
            n.mode = ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (IRQ_PEND_I) begin
            n.mode = ST_RUN;
            n.wake = 1'b1;
          end
        end
        ST_PD: begin
          if (wake_low) begin
            n.mode = ST_PD_WAKE;
          end
        end
        ST_PD_WAKE: begin
          if (wake_high) begin
            n.mode = ST_RUN;
            n.wake = 1'b1;
          end
        end
        ST_EMUL: begin
          n.mode = ST_EMUL;
        end
      endcase
    end
    // Oscillator stops in power-down unless reset is being counted
    n.ce.osc_run = (n.mode != ST_PD) | n.f[`RLPE_PIN_RST];
    n.ce.phase = phase;
    n.ce.mcyc = phase & (r.ph_cnt == `RLPE_PHASE_PER_MCYC - 3'd1);
    n.ce.core = phase & (n.mode == ST_RUN);
    n.ce.periph = phase & ((n.mode == ST_RUN) | (n.mode == ST_IDLE));
    n.core_rst = (n.mode == ST_RESET);
    // Pin control per mode
    n.pc = '0;
    unique case (n.mode)
      ST_RUN: begin
        n.pc.ale = ALE_CORE_I;
        n.pc.ale_oe = 1'b1;
        n.pc.prog_store_strobe_n_n = PROG_STORE_STROBE_N_N_CORE_I;
        n.pc.prog_store_strobe_n_oe = 1'b1;
      end
      ST_IDLE: begin
        n.pc.ale = 1'b1;
        n.pc.ale_oe = 1'b1;
        n.pc.prog_store_strobe_n_n = 1'b1;
        n.pc.prog_store_strobe_n_oe = 1'b1;
        n.pc.p0_float = EXT_PROG_I;
        n.pc.p2_addr = EXT_PROG_I;
        n.pc.port_hold = 1'b1;
      end
      ST_PD, ST_PD_WAKE: begin
        n.pc.ale_oe = 1'b1;
        n.pc.prog_store_strobe_n_oe = 1'b1;
        n.pc.p0_float = EXT_PROG_I;
        n.pc.port_hold = 1'b1;
      end
      ST_EMUL: begin
        n.pc.p0_float = 1'b1;
        n.pc.weak_pull = 1'b1;
      end
      ST_RESET: begin
        n.pc.weak_pull = 1'b1;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      r <= '0;
      r.s1 <= `RLPE_PIN_RESET;
      r.s2 <= `RLPE_PIN_RESET;
      r.s3 <= `RLPE_PIN_RESET;
      r.f <= `RLPE_PIN_RESET;
      r.mode <= ST_RESET;
      r.ce.osc_run <= 1'b1;
      r.core_rst <= 1'b1;
      r.pc.weak_pull <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Reset pin forces the ports without waiting for a clock
  always_ff @(posedge MCLK_I or posedge RST_PIN_I) begin
    if (RST_PIN_I) begin
      port_rst <= 1'b1;
    end else begin
      port_rst <= r.f[`RLPE_PIN_RST];
    end
  end

  assign MODE_O = r.mode;
  assign CLK_EN_O = r.ce;
  assign CORE_RST_O = r.core_rst;
  assign WAKE_IRQ_O = r.wake;
  assign PORT_RST_O = port_rst;
  assign PIN_CTL_O = r.pc;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_PORT_RST: assert property (RST_PIN_I |-> PORT_RST_O)
    else $error("ports not forced during reset");
  AST_DIV2: assert property (r.ce.phase |=> !r.ce.phase)
    else $error("phase enable not divided");
  AST_IDLE_CORE: assert property (r.mode == ST_IDLE |-> !r.ce.core)
    else $error("core stepped in idle");
  AST_IDLE_WAKE: assert property ((r.mode == ST_IDLE && IRQ_PEND_I && !rst_hit)
    |=> r.mode == ST_RUN && r.wake)
    else $error("interrupt did not end idle");
  AST_RST_HIT: assert property (rst_hit |=> r.mode == ST_RESET && r.core_rst)
    else $error("qualified reset not taken");
  AST_PD_OSC: assert property ((r.mode == ST_PD && !r.f[`RLPE_PIN_RST]) |-> !r.ce.osc_run)
    else $error("oscillator runs in power-down");
  AST_PD_EXIT: assert property ((r.mode == ST_PD_WAKE && wake_high && !rst_hit)
    |=> r.mode == ST_RUN ##1 r.mode != ST_PD_WAKE)
    else $error("power-down exit not completed");
  AST_EMUL: assert property (r.mode == ST_EMUL |-> r.pc.p0_float && r.pc.weak_pull
    && !r.pc.ale_oe && r.ce.osc_run)
    else $error("emulation pin state wrong");
  AST_EMUL_STAY: assert property ((r.mode == ST_EMUL && !rst_hit) |=> r.mode == ST_EMUL)
    else $error("emulation left without reset");
  AST_IDLE_PINS: assert property (r.mode == ST_IDLE |-> r.pc.ale && r.pc.prog_store_strobe_n_n
    && r.pc.ale_oe)
    else $error("idle strobes not high");
  AST_PD_PINS: assert property (r.mode == ST_PD |-> !r.pc.ale && !r.pc.prog_store_strobe_n_n
    && r.pc.prog_store_strobe_n_oe)
    else $error("power-down strobes not low");

  COV_IDLE: cover property (r.mode == ST_IDLE ##1 r.mode == ST_RUN);
  COV_PD: cover property (r.mode == ST_PD_WAKE ##1 r.mode == ST_RUN);
  COV_EMUL: cover property (r.mode == ST_RESET ##1 r.mode == ST_EMUL);
endmodule

// file: tb/osc_rst_model.sv
// Purpose: oscillator and reset source beside the controller
// Assumes: 25 MHz oscillator, stretched reset request
// Notes: oscillator stands still while disabled
`timescale 1ns/10ps
module osc_rst_model (
  // Control
  input  wire logic osc_en_i,
  input  wire logic rst_req_i,
  // Pins
  output logic      osc_o,
  output logic      rst_pin_o
);
  logic [5:0] hold = 6'h00;
  initial osc_o = 1'b0;
  always #20 if (osc_en_i) osc_o = ~osc_o;
  always @(posedge osc_o or posedge rst_req_i) begin
    if (rst_req_i) hold <= 6'h1E;
    else if (hold != 6'h00) hold <= hold - 6'h01;
  end
  assign rst_pin_o = rst_req_i | (hold != 6'h00);
endmodule

// file: tb/reset_lowpower_emul_ctrl_tb.sv
// Purpose: self-checking bench for reset_lowpower_emul_ctrl
// Assumes: oscillator model runs only when enabled
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module reset_lowpower_emul_ctrl_tb;
  import rlpe_pkg::*;
  logic       mclk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       osc;
  logic       rst_pin;
  logic       rst_req = 1'b1;
  logic [1:0] irq_n = 2'h3;
  logic [1:0] wake_en = 2'h0;
  logic       ale_pin = 1'b1;
  logic       prog_store_strobe_n_pin = 1'b1;
  logic       idle_req = 1'b0;
  logic       pd_req = 1'b0;
  logic       irq_pend = 1'b0;
  logic       ext = 1'b0;
  mode_t      mode;
  clk_en_t    clk_en;
  logic       core_rst;
  logic       wake_irq;
  logic       port_rst;
  pin_ctl_t   pin;
  int         n_fail = 0;
  int         samples_checked = 0;
  always #2.5 mclk = ~mclk;
  osc_rst_model osc_rst_model_i (
    .osc_en_i(clk_en.osc_run), .rst_req_i(rst_req), .osc_o(osc), .rst_pin_o(rst_pin));
  reset_lowpower_emul_ctrl reset_lowpower_emul_ctrl_i (
    .MCLK_I(mclk), .SYS_RST_I(sys_rst), .RST_PIN_I(rst_pin), .OSC_IN_I(osc),
    .IRQ0_N_I(irq_n[0]), .IRQ1_N_I(irq_n[1]), .ALE_PIN_I(ale_pin), .PROG_STORE_STROBE_N_N_PIN_I(prog_store_strobe_n_pin),
    .IDLE_REQ_I(idle_req), .PD_REQ_I(pd_req), .IRQ_PEND_I(irq_pend),
    .IRQ0_WAKE_EN_I(wake_en[0]), .IRQ1_WAKE_EN_I(wake_en[1]), .EXT_PROG_I(ext),
    .ALE_CORE_I(1'b0), .PROG_STORE_STROBE_N_N_CORE_I(1'b1), .MODE_O(mode), .CLK_EN_O(clk_en),
    .CORE_RST_O(core_rst), .WAKE_IRQ_O(wake_irq), .PORT_RST_O(port_rst), .PIN_CTL_O(pin));
  task automatic summarize;
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_mode(input mode_t m);
    for (int k = 0; k < 4000; k++) begin
      @(negedge mclk);
      if (mode === m) return;
    end
    chk("mode_wait", 8'(m), 8'(mode));
    summarize();
  endtask
  task automatic t_reset;
    @(negedge mclk);
    rst_req = 1'b1;
    #1;
    chk("port_rst", 8'h01, 8'(port_rst));
    wait_mode(ST_RESET);
    chk("core_rst", 8'h01, 8'(core_rst));
    rst_req = 1'b0;
    wait_mode(ST_RUN);
    chk("core_rst", 8'h00, 8'(core_rst));
    chk("port_rst", 8'h00, 8'(port_rst));
  endtask
  task automatic t_clock;
    int np;
    int nc;
    np = 0;
    nc = 0;
    for (int k = 0; k < 200; k++) begin
      if (clk_en.mcyc === 1'b1) break;
      @(negedge mclk);
    end
    for (int k = 0; k < 200; k++) begin
      @(negedge mclk);
      nc++;
      if (clk_en.phase === 1'b1) np++;
      if (clk_en.mcyc === 1'b1) break;
    end
    chk("phases", 8'h06, 8'(np));
    chk("mcyc_gap", 8'h60, 8'(nc));
  endtask
  task automatic t_idle(input logic e);
    int nc;
    int np;
    nc = 0;
    np = 0;
    ext = e;
    @(negedge mclk) idle_req = 1'b1;
    @(negedge mclk) idle_req = 1'b0;
    chk("mode", 8'(ST_IDLE), 8'(mode));
    chk("strobes", 8'h03, 8'({pin.ale, pin.prog_store_strobe_n_n}));
    chk("port_hold", 8'h01, 8'(pin.port_hold));
    chk("p0_p2", 8'({e, e}), 8'({pin.p0_float, pin.p2_addr}));
    repeat (40) begin
      @(negedge mclk);
      if (clk_en.core !== 1'b0) nc++;
      if (clk_en.periph === 1'b1) np++;
    end
    chk("core_en", 8'h00, 8'(nc));
    chk("periph_en", 8'h01, 8'(np > 0));
    irq_pend = 1'b1;
    @(negedge mclk) irq_pend = 1'b0;
    chk("mode", 8'(ST_RUN), 8'(mode));
    chk("wake_irq", 8'h01, 8'(wake_irq));
  endtask
  task automatic t_pd(input int w);
    wake_en = 2'h1 << w;
    @(negedge mclk) pd_req = 1'b1;
    @(negedge mclk) pd_req = 1'b0;
    chk("mode", 8'(ST_PD), 8'(mode));
    chk("osc_run", 8'h00, 8'(clk_en.osc_run));
    chk("strobes", 8'h03, 8'({pin.ale, pin.prog_store_strobe_n_n, pin.ale_oe, pin.prog_store_strobe_n_oe}));
    chk("p0_float", 8'(ext), 8'(pin.p0_float));
    chk("port_hold", 8'h01, 8'(pin.port_hold));
    irq_n[1 - w] = 1'b0;
    repeat (20) @(negedge mclk);
    chk("mode", 8'(ST_PD), 8'(mode));
    irq_n = 2'h3;
    @(negedge mclk) irq_n[w] = 1'b0;
    wait_mode(ST_PD_WAKE);
    chk("osc_run", 8'h01, 8'(clk_en.osc_run));
    repeat (40) @(negedge mclk);
    chk("mode", 8'(ST_PD_WAKE), 8'(mode));
    irq_n[w] = 1'b1;
    wait_mode(ST_RUN);
    chk("wake_irq", 8'h01, 8'(wake_irq));
    chk("core_rst", 8'h00, 8'(core_rst));
  endtask
  task automatic t_emul(input logic p);
    @(negedge mclk) ale_pin = 1'b0;
    prog_store_strobe_n_pin = p;
    rst_req = 1'b1;
    wait_mode(ST_RESET);
    rst_req = 1'b0;
    wait_mode(p ? ST_EMUL : ST_RUN);
    chk("emul_mode", 8'(p ? ST_EMUL : ST_RUN), 8'(mode));
    ale_pin = 1'b1;
    prog_store_strobe_n_pin = 1'b1;
    if (p) begin
      chk("emul_pins", 8'h19,
          8'({pin.p0_float, pin.weak_pull, pin.ale_oe, pin.prog_store_strobe_n_oe, clk_en.osc_run}));
      @(negedge mclk) idle_req = 1'b1;
      @(negedge mclk) idle_req = 1'b0;
      repeat (4) @(negedge mclk);
      chk("mode", 8'(ST_EMUL), 8'(mode));
      t_reset();
    end
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (60) @(negedge mclk);
    rst_req = 1'b0;
    wait_mode(ST_RUN);
    t_clock();
    t_reset();
    t_idle(1'b0);
    t_idle(1'b1);
    t_pd(0);
    t_pd(1);
    @(negedge mclk) idle_req = 1'b1;
    @(negedge mclk) idle_req = 1'b0;
    t_reset();
    t_emul(1'b0);
    t_emul(1'b1);
    summarize();
  end
endmodule
